// File: shared/btth_pkg.sv
// target-termination handler: shared constants, register map and types
// assumes a single 100 MHz clock shared by the handler and its queue logic
package btth_pkg;
   // clock
   localparam int CLK_MHZ = 100;
   // register map, byte offsets on the plain register port
   localparam logic [7:0] OFS_CONTROL = 8'h04; // serr enable and friends
   localparam logic [7:0] OFS_STATUS = 8'h08; // sticky event bits, write one to clear
   localparam logic [7:0] OFS_RETRY_LIMIT = 8'h0C; // attempt ceiling, zero means 2**32
   localparam logic [7:0] OFS_EVENT_DISABLE = 8'h64; // system_error_event_disable
   // field positions
   localparam int CTL_SERR_EN_BIT = 8;
   localparam int DIS_POSTED_BIT = 2;
   localparam int DIS_DELAYED_BIT = 5;
   localparam int ST_RTA_BIT = 0; // target abort received on target side
   localparam int ST_STA_BIT = 1; // target abort signaled on initiator side
   localparam int ST_SSE_BIT = 2; // system error signaled on primary side
   localparam int ST_RMA_BIT = 3; // master abort received on target side
   localparam int ST_BUSY_BIT = 8; // attempt in flight, live
   // reset values
   localparam logic [31:0] RETRY_LIMIT_RST = 32'h0100_0000; // 2**24 attempts
   localparam logic [7:0] EVENT_DISABLE_RST = 8'h00;
   localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
   // bus timing, in bus clocks
   localparam logic [2:0] DEVSEL_WAIT_CLKS = 3'h5;
   // bus commands
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
   localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hF;
   // queue slots
   localparam int SLOT_NUM = 4;
   localparam int SLOT_W = 2;
   // transaction kinds
   typedef enum logic [1:0] {K_DELAYED_WRITE, K_POSTED_WRITE, K_DELAYED_READ, K_UNUSED} btth_kind_t;
   // outcome of the latest attempt of a slot
   typedef enum logic [2:0] {R_PENDING, R_RETRY, R_NORMAL, R_DISC, R_TABORT, R_MABORT} btth_res_t;
   // what the master engine does with a slot after an attempt
   typedef enum logic [1:0] {A_NONE, A_AGAIN, A_DONE, A_DISCARD} btth_act_t;
   // answer to the original initiator's repeated request
   typedef enum logic [2:0] {P_NONE, P_RETRY, P_DATA_LAST, P_DATA_DISC, P_TABORT, P_MABORT} btth_resp_t;
   // attempt watcher states
   typedef enum logic [1:0] {ST_IDLE, ST_SELECT, ST_XFER} btth_state_t;
endpackage

// File: core/btth_core.sv
// target-termination handler of the bridge's forwarding master
// assumes queue and master engine on CLK; target-bus pins arrive asynchronously
// How it works
// (RULE_01) delayed write repeats until data, abort
// (RULE_02) retried attempts capped, default 2**24
// (RULE_03) delayed write done: disconnect multi-phase initiator
// (RULE_04) pending delayed write answered with retry
// (RULE_05) delayed write abort: reflect, set both bits
// (RULE_06) delayed write limit raises system error
// (RULE_07) posted write results never reach initiator
// (RULE_08) posted retry reuses original start address
// (RULE_09) posted disconnect resumes at undelivered dword
// (RULE_10) partial invalidate write resumes as write
// (RULE_11) posted abort: status, optional system error
// (RULE_12) posted non-delivery limit raises system error
// (RULE_13) delayed read repeats until data, abort
// (RULE_14) delayed read retried, limit 2**24 default
// (RULE_15) read completion disconnect depends on prefetch
// (RULE_16) read disconnect reflected when more wanted
// (RULE_17) delayed read abort: reflect, set both bits
// (RULE_18) delayed read limit raises system error
// (RULE_19) no devsel in five clocks: master abort
// (RULE_20) per-slot attempt counter, cleared, then frozen
`timescale 1ns/100ps
module btth_core import btth_pkg::*; (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // transaction load from the queue
   input wire logic TXN_LOAD,
   input wire logic [1:0] TXN_SLOT,
   input wire logic [1:0] TXN_KIND,
   input wire logic [31:0] TXN_ADDR,
   input wire logic [3:0] TXN_CMD,
   input wire logic [7:0] TXN_DWORDS,
   input wire logic TXN_PREFETCH,
   // attempt announce from the master engine
   input wire logic ATT_START,
   input wire logic [1:0] ATT_SLOT,
   output logic [31:0] ATT_ADDR,
   output logic [3:0] ATT_CMD,
   // attempt outcome to the master engine
   output logic END_VALID,
   output logic [1:0] END_SLOT,
   output logic [1:0] END_ACTION,
   // repeated request from the original initiator
   input wire logic INIT_POLL,
   input wire logic [1:0] INIT_SLOT,
   input wire logic INIT_MORE,
   output logic INIT_RESP_VALID,
   output logic [2:0] INIT_RESP,
   // target-bus pins, observed only
   input wire logic T_FRAME_N,
   input wire logic T_IRDY_N,
   input wire logic T_TRDY_N,
   input wire logic T_STOP_N,
   input wire logic T_DEVSEL_N,
   // primary system error, open drain
   input wire logic PRIMARY_SYSTEM_ERROR_OUT_I_N,
   output logic PRIMARY_SYSTEM_ERROR_OUT_O_N,
   output logic PRIMARY_SYSTEM_ERROR_OUT_OE
);

   // register file
   logic [31:0] control_reg; // serr enable lives here
   logic [31:0] retry_limit_reg; // attempt ceiling
   logic [7:0] system_error_event_disable_reg;
   logic [3:0] status_reg; // sticky event bits
   // pin synchronisers: first stage read only by second
   logic [5:0] pin_s1_reg;
   logic [5:0] pin_s2_reg;
   logic frame_prev_reg; // for the assertion edge of frame
   // slot storage
   logic slot_valid[SLOT_NUM];
   btth_kind_t slot_kind[SLOT_NUM];
   logic [31:0] slot_addr[SLOT_NUM];
   logic [3:0] slot_cmd[SLOT_NUM];
   logic [7:0] slot_left[SLOT_NUM]; // dwords still buffered, posted only
   logic slot_pref[SLOT_NUM];
   btth_res_t slot_res[SLOT_NUM];
   logic [31:0] slot_cnt[SLOT_NUM]; // attempts sent back to try again: retries, and posted disconnects with data left
   // attempt watcher
   btth_state_t state_reg;
   logic armed_reg; // master engine announced an attempt
   logic [SLOT_W-1:0] cur_slot_reg;
   logic [2:0] sel_cnt_reg;
   logic [7:0] xfer_cnt_reg; // data phases of this attempt
   // output flops
   logic serr_reg;
   logic end_valid_reg;
   btth_act_t end_action_reg;
   logic [1:0] end_slot_reg;
   logic init_valid_reg;
   btth_resp_t init_resp_reg;
   logic [31:0] att_addr_reg;
   logic [3:0] att_cmd_reg;
   logic [31:0] rdata_reg;
   // combinational outcome
   logic term_ev;
   btth_res_t term_res;
   logic [7:0] n_xfer; // data phases including the ending one
   logic data_now;
   logic limit_hit;
   logic serr_fire;
   logic set_rta, set_sta, set_sse, set_rma;
   btth_act_t act_next;
   btth_resp_t resp_next;
   logic init_poll_done; // final answer retires the slot

   // synchronised pin view
   wire frame_n = pin_s2_reg[0];
   wire irdy_n = pin_s2_reg[1];
   wire trdy_n = pin_s2_reg[2];
   wire stop_n = pin_s2_reg[3];
   wire devsel_n = pin_s2_reg[4];
   wire serr_seen_n = pin_s2_reg[5];

   // true for the kinds whose outcome goes back to the initiator
   function automatic logic is_delayed(input btth_kind_t k);
      return (k == K_DELAYED_WRITE) || (k == K_DELAYED_READ);
   endfunction

   // next attempt count wraps at 2**32, so a ceiling of zero means 2**32
   function automatic logic at_limit(input logic [31:0] cnt, input logic [31:0] lim);
      return (cnt + 32'h0000_0001) == lim;
   endfunction

   // two flops on every pin before any logic looks at it
   always_ff @(posedge CLK) begin
      if (SRST) begin
         pin_s1_reg <= 6'h3F;
         pin_s2_reg <= 6'h3F;
         frame_prev_reg <= 1'b1;
      end else begin
         pin_s1_reg <= {PRIMARY_SYSTEM_ERROR_OUT_I_N, T_DEVSEL_N, T_STOP_N, T_TRDY_N, T_IRDY_N, T_FRAME_N};
         pin_s2_reg <= pin_s1_reg;
         frame_prev_reg <= frame_n;
      end
   end

   // termination decode while an attempt is watched
   always_comb begin
      term_ev = 1'b0;
      term_res = R_PENDING;
      data_now = (state_reg == ST_XFER) && !irdy_n && !trdy_n;
      n_xfer = xfer_cnt_reg + {7'h00, data_now};
      if (state_reg == ST_SELECT && devsel_n && sel_cnt_reg == DEVSEL_WAIT_CLKS - 3'h1) begin
         term_ev = 1'b1; // nobody claimed it
         term_res = R_MABORT; // RULE_19
      end else if (state_reg == ST_XFER) begin
         if (!stop_n && devsel_n) begin
            term_ev = 1'b1;
            term_res = R_TABORT;
         end else if (!stop_n) begin
            term_ev = 1'b1;
            term_res = (n_xfer == 8'h00) ? R_RETRY : R_DISC;
         end else if (frame_n && data_now) begin
            term_ev = 1'b1;
            term_res = R_NORMAL;
         end
      end
   end

   // decide follow-up, error events and status sets for an ending attempt
   always_comb begin
      act_next = A_NONE;
      limit_hit = at_limit(slot_cnt[cur_slot_reg], retry_limit_reg);
      serr_fire = 1'b0;
      set_rta = 1'b0;
      set_rma = 1'b0;
      set_sse = 1'b0;
      if (term_ev) begin
         if (slot_kind[cur_slot_reg] == K_POSTED_WRITE) begin
            unique case (term_res)
               R_NORMAL: act_next = A_DONE; // RULE_07
               R_TABORT: begin
                  act_next = A_DISCARD;
                  set_rta = 1'b1; // RULE_11
                  serr_fire = control_reg[CTL_SERR_EN_BIT]; // RULE_11
               end
               R_MABORT: begin
                  act_next = A_DISCARD; // buffered data dropped
                  set_rma = 1'b1;
               end
               default: begin
                  // retry or disconnect: anything left is tried again until the limit
                  if (term_res == R_DISC && slot_left[cur_slot_reg] == n_xfer) begin
                     act_next = A_DONE;
                  end else if (limit_hit) begin
                     act_next = A_DISCARD; // RULE_12
                     serr_fire = control_reg[CTL_SERR_EN_BIT] && !system_error_event_disable_reg[DIS_POSTED_BIT];
                  end else begin
                     act_next = A_AGAIN; // RULE_08 RULE_09
                  end
               end
            endcase
         end else begin
            unique case (term_res)
               R_RETRY: begin
                  if (limit_hit) begin
                     act_next = A_DISCARD; // RULE_02 RULE_14
                     // RULE_06 RULE_18
                     serr_fire = control_reg[CTL_SERR_EN_BIT] && !system_error_event_disable_reg[DIS_DELAYED_BIT];
                  end else begin
                     act_next = A_AGAIN; // RULE_01 RULE_13
                  end
               end
               R_TABORT: begin
                  act_next = A_DONE;
                  set_rta = 1'b1; // RULE_05 RULE_17
               end
               R_MABORT: begin
                  act_next = A_DONE;
                  set_rma = 1'b1;
               end
               default: act_next = A_DONE; // data moved: RULE_01 RULE_13
            endcase
         end
      end
      set_sse = serr_fire;
   end

   // answer to a repeated request; posted slots never answer
   always_comb begin
      resp_next = P_NONE;
      set_sta = 1'b0;
      if (INIT_POLL && slot_valid[INIT_SLOT] && is_delayed(slot_kind[INIT_SLOT])) begin // RULE_07
         unique case (slot_res[INIT_SLOT])
            R_PENDING, R_RETRY: resp_next = P_RETRY; // RULE_04
            R_TABORT: begin
               resp_next = P_TABORT; // RULE_05 RULE_17
               set_sta = 1'b1;
            end
            R_MABORT: resp_next = P_MABORT; // no devsel given back
            R_NORMAL: begin
               if (slot_kind[INIT_SLOT] == K_DELAYED_READ && !slot_pref[INIT_SLOT]) begin
                  resp_next = P_DATA_DISC; // RULE_15
               end else begin
                  resp_next = INIT_MORE ? P_DATA_DISC : P_DATA_LAST; // RULE_03 RULE_15
               end
            end
            default: resp_next = INIT_MORE ? P_DATA_DISC : P_DATA_LAST; // RULE_03 RULE_16
         endcase
      end
   end

   // attempt watcher: frame edge, devsel window, data phases
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_reg <= ST_IDLE;
         armed_reg <= 1'b0;
         cur_slot_reg <= '0;
         sel_cnt_reg <= 3'h0;
         xfer_cnt_reg <= 8'h00;
      end else begin
         if (ATT_START) begin
            armed_reg <= 1'b1;
            cur_slot_reg <= ATT_SLOT;
         end
         unique case (state_reg)
            ST_IDLE: begin
               // a frame only counts once the engine has announced it
               if (armed_reg && !ATT_START && !frame_n && frame_prev_reg) begin
                  armed_reg <= 1'b0;
                  state_reg <= ST_SELECT;
                  sel_cnt_reg <= 3'h0;
                  xfer_cnt_reg <= 8'h00;
               end
            end
            ST_SELECT: begin
               if (!devsel_n) begin
                  state_reg <= ST_XFER;
               end else if (term_ev) begin
                  state_reg <= ST_IDLE; // RULE_19
               end else begin
                  sel_cnt_reg <= sel_cnt_reg + 3'h1;
               end
            end
            ST_XFER: begin
               xfer_cnt_reg <= n_xfer;
               if (term_ev) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // slot storage: load, attempt results, final answer frees delayed slots
   always_ff @(posedge CLK) begin
      if (SRST) begin
         for (int i = 0; i < SLOT_NUM; i++) begin
            slot_valid[i] <= 1'b0;
            slot_kind[i] <= K_UNUSED;
            slot_addr[i] <= 32'h0000_0000;
            slot_cmd[i] <= 4'h0;
            slot_left[i] <= 8'h00;
            slot_pref[i] <= 1'b0;
            slot_res[i] <= R_PENDING;
            slot_cnt[i] <= 32'h0000_0000;
         end
      end else begin
         if (init_poll_done) begin
            slot_valid[INIT_SLOT] <= 1'b0; // answered: stop counting, RULE_20
         end
         if (term_ev && slot_valid[cur_slot_reg]) begin
            slot_res[cur_slot_reg] <= term_res;
            if (act_next == A_AGAIN) begin
               slot_cnt[cur_slot_reg] <= slot_cnt[cur_slot_reg] + 32'h0000_0001; // RULE_02 RULE_20
            end
            if (act_next == A_DISCARD || (act_next == A_DONE && slot_kind[cur_slot_reg] == K_POSTED_WRITE)) begin
               slot_valid[cur_slot_reg] <= 1'b0; // RULE_20
            end
            if (slot_kind[cur_slot_reg] == K_POSTED_WRITE && term_res == R_DISC) begin
               slot_addr[cur_slot_reg] <= slot_addr[cur_slot_reg] + {22'h00_0000, n_xfer, 2'h0}; // RULE_09
               slot_left[cur_slot_reg] <= slot_left[cur_slot_reg] - n_xfer;
               if (slot_cmd[cur_slot_reg] == CMD_MEM_WRITE_INV) begin
                  slot_cmd[cur_slot_reg] <= CMD_MEM_WRITE; // RULE_10
               end
            end
         end
         if (TXN_LOAD) begin
            slot_valid[TXN_SLOT] <= 1'b1;
            slot_kind[TXN_SLOT] <= btth_kind_t'(TXN_KIND);
            slot_addr[TXN_SLOT] <= TXN_ADDR;
            slot_cmd[TXN_SLOT] <= TXN_CMD;
            slot_left[TXN_SLOT] <= TXN_DWORDS;
            slot_pref[TXN_SLOT] <= TXN_PREFETCH;
            slot_res[TXN_SLOT] <= R_PENDING;
            slot_cnt[TXN_SLOT] <= 32'h0000_0000; // RULE_20
         end
      end
   end

   // a final answer retires the delayed slot
   assign init_poll_done = (resp_next != P_NONE) && (resp_next != P_RETRY);

   // engine-facing outputs: attempt address and command, outcome pulse
   always_ff @(posedge CLK) begin
      if (SRST) begin
         att_addr_reg <= 32'h0000_0000;
         att_cmd_reg <= 4'h0;
         end_valid_reg <= 1'b0;
         end_action_reg <= A_NONE;
         end_slot_reg <= '0;
      end else begin
         if (ATT_START) begin
            att_addr_reg <= slot_addr[ATT_SLOT]; // RULE_08 RULE_09
            att_cmd_reg <= slot_cmd[ATT_SLOT]; // RULE_10
         end
         end_valid_reg <= term_ev;
         end_action_reg <= act_next;
         end_slot_reg <= cur_slot_reg;
      end
   end

   // initiator-facing answer, one cycle after the poll
   always_ff @(posedge CLK) begin
      if (SRST) begin
         init_valid_reg <= 1'b0;
         init_resp_reg <= P_NONE;
      end else begin
         init_valid_reg <= INIT_POLL;
         init_resp_reg <= resp_next;
      end
   end

   // system error: one-clock low drive, as pci expects of serr
   always_ff @(posedge CLK) begin
      if (SRST) begin
         serr_reg <= 1'b0;
      end else begin
         serr_reg <= serr_fire; // RULE_06 RULE_11 RULE_12 RULE_18
      end
   end

   // software registers; a hardware set beats a same-cycle clear
   always_ff @(posedge CLK) begin
      if (SRST) begin
         control_reg <= CONTROL_RST;
         retry_limit_reg <= RETRY_LIMIT_RST;
         system_error_event_disable_reg <= EVENT_DISABLE_RST;
         status_reg <= 4'h0;
      end else begin
         if (REG_WR && REG_ADDR == OFS_CONTROL) begin
            control_reg <= REG_WDATA;
         end
         if (REG_WR && REG_ADDR == OFS_RETRY_LIMIT) begin
            retry_limit_reg <= REG_WDATA; // RULE_02
         end
         if (REG_WR && REG_ADDR == OFS_EVENT_DISABLE) begin
            system_error_event_disable_reg <= REG_WDATA[7:0];
         end
         status_reg <= (status_reg & ~((REG_WR && REG_ADDR == OFS_STATUS) ? REG_WDATA[3:0] : 4'h0))
            | {set_rma, set_sse, set_sta, set_rta};
      end
   end

   // read data, valid only the cycle after the strobe; unmapped reads zero
   always_ff @(posedge CLK) begin
      if (SRST) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= 32'h0000_0000;
         if (REG_RD) begin
            unique case (REG_ADDR)
               OFS_CONTROL: rdata_reg <= control_reg;
               OFS_STATUS: begin
                  rdata_reg[3:0] <= status_reg;
                  rdata_reg[ST_BUSY_BIT] <= (state_reg != ST_IDLE);
                  rdata_reg[ST_BUSY_BIT + 1] <= !serr_seen_n; // line seen low
               end
               OFS_RETRY_LIMIT: rdata_reg <= retry_limit_reg;
               OFS_EVENT_DISABLE: rdata_reg[7:0] <= system_error_event_disable_reg;
               default: rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ports straight from flops, except the serr data tied low
   assign REG_RDATA = rdata_reg;
   assign ATT_ADDR = att_addr_reg;
   assign ATT_CMD = att_cmd_reg;
   assign END_VALID = end_valid_reg;
   assign END_SLOT = end_slot_reg;
   assign END_ACTION = end_action_reg;
   assign INIT_RESP_VALID = init_valid_reg;
   assign INIT_RESP = init_resp_reg;
   assign PRIMARY_SYSTEM_ERROR_OUT_O_N = 1'b0; // open drain: only ever pulls low
   assign PRIMARY_SYSTEM_ERROR_OUT_OE = serr_reg;

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   serr_gate_a: assert property (serr_reg |-> $past(control_reg[CTL_SERR_EN_BIT])) // RULE_06
      else $error("system error driven while disabled");
   devsel_window_a: assert property (state_reg == ST_SELECT |-> sel_cnt_reg < DEVSEL_WAIT_CLKS) // RULE_19
      else $error("devsel wait ran past five clocks");
   mabort_status_a: assert property (term_ev && term_res == R_MABORT |=> status_reg[ST_RMA_BIT]) // RULE_19
      else $error("master abort not recorded");
   retry_addr_kept_a: assert property (term_ev && term_res == R_RETRY && slot_kind[cur_slot_reg] == K_POSTED_WRITE
      && !TXN_LOAD |=> slot_addr[$past(cur_slot_reg)] == $past(slot_addr[cur_slot_reg])) // RULE_08
      else $error("posted retry moved the address");
   disc_addr_step_a: assert property (term_ev && term_res == R_DISC && slot_kind[cur_slot_reg] == K_POSTED_WRITE
      && !TXN_LOAD |=> slot_addr[$past(cur_slot_reg)] == $past(slot_addr[cur_slot_reg]) + {$past(n_xfer), 2'h0}) // RULE_09
      else $error("posted disconnect address not advanced");
   mwi_demote_a: assert property (term_ev && term_res == R_DISC && slot_cmd[cur_slot_reg] == CMD_MEM_WRITE_INV
      && slot_kind[cur_slot_reg] == K_POSTED_WRITE && !TXN_LOAD |=> slot_cmd[$past(cur_slot_reg)] == CMD_MEM_WRITE) // RULE_10
      else $error("invalidate write not demoted");
   abort_status_a: assert property (term_ev && term_res == R_TABORT |=> status_reg[ST_RTA_BIT] && end_valid_reg) // RULE_05
      else $error("target abort not recorded");
   posted_silent_a: assert property (INIT_POLL && slot_kind[INIT_SLOT] == K_POSTED_WRITE |=> init_resp_reg == P_NONE) // RULE_07
      else $error("posted write answered the initiator");
   pending_retry_a: assert property (INIT_POLL && slot_valid[INIT_SLOT] && is_delayed(slot_kind[INIT_SLOT])
      && slot_res[INIT_SLOT] == R_RETRY |=> init_resp_reg == P_RETRY) // RULE_04
      else $error("pending delayed request not retried");
   count_clear_a: assert property (TXN_LOAD |=> slot_cnt[$past(TXN_SLOT)] == 32'h0000_0000) // RULE_20
      else $error("attempt counter not cleared on load");
   delivered_done_a: assert property (term_ev && is_delayed(slot_kind[cur_slot_reg]) && n_xfer != 8'h00
      |=> end_action_reg == A_DONE) // RULE_01
      else $error("delayed data transfer did not finish the request");

   retry_seen_c: cover property (term_ev && term_res == R_RETRY);
   disc_resume_c: cover property (end_valid_reg && end_action_reg == A_AGAIN ##[1:50] end_valid_reg && end_action_reg == A_DONE);
   abort_reflect_c: cover property (init_valid_reg && init_resp_reg == P_TABORT);
   serr_pulse_c: cover property (serr_reg);
endmodule

// File: tb/btth_target_model.sv
// target-bus device model: one frame per go pulse
// assumes go only while idle; outside a frame the model drives every pin high
`timescale 1ns/100ps
module btth_target_model (
   // control
   input wire logic clk,
   input wire logic go,
   input wire logic [2:0] mode,
   // {frame, irdy, trdy, stop, devsel}, low active
   output logic [4:0] pins
);
   int step = 99; // cycle within the frame
   // third cycle for retry, normal, disconnect, abort, silent
   logic [4:0] last [5] = '{5'h04, 5'h12, 5'h00, 5'h05, 5'h07};
   // silent mode holds the frame past the select window
   always @(posedge clk) begin
      step <= go ? 0 : (step < 99 ? step + 1 : 99);
      if (step == 0 || (mode == 3'h4 && step < 7)) pins <= 5'h07;
      else if (step == 1) pins <= 5'h06;
      else if (step == 2) pins <= last[mode];
      else pins <= 5'h1F;
   end
endmodule

// File: tb/btth_test.sv
// bench for the target-termination handler
// assumes btth_pkg and the target model compiled first
`timescale 1ns/100ps
module bridge_target_termination_handler_test import btth_pkg::*;;
   logic CLK = 0, SRST = 1, REG_WR = 0, REG_RD = 0, TXN_LOAD = 0, TXN_PREFETCH = 0;
   logic ATT_START = 0, INIT_POLL = 0, INIT_MORE = 0, go = 0;
   logic [1:0] TXN_SLOT = 0, TXN_KIND = 0, ATT_SLOT = 0, INIT_SLOT = 0, END_SLOT, END_ACTION;
   logic [7:0] REG_ADDR = 0, TXN_DWORDS = 0;
   logic [31:0] REG_WDATA = 0, TXN_ADDR = 0, REG_RDATA, ATT_ADDR;
   logic [3:0] TXN_CMD = 0, ATT_CMD;
   logic [2:0] INIT_RESP, mode = 0;
   logic END_VALID, INIT_RESP_VALID, PRIMARY_SYSTEM_ERROR_OUT_O_N, PRIMARY_SYSTEM_ERROR_OUT_OE;
   logic T_FRAME_N, T_IRDY_N, T_TRDY_N, T_STOP_N, T_DEVSEL_N;
   // open-drain line, pulled up when not driven
   wire PRIMARY_SYSTEM_ERROR_OUT_I_N = PRIMARY_SYSTEM_ERROR_OUT_OE ? PRIMARY_SYSTEM_ERROR_OUT_O_N : 1'b1;
   int fails = 0, checked = 0, cycles = 0, pulses = 0;
   btth_core btth_core_i (.*);
   btth_target_model btth_target_model_i (.clk(CLK), .go(go), .mode(mode),
      .pins({T_FRAME_N, T_IRDY_N, T_TRDY_N, T_STOP_N, T_DEVSEL_N}));
   always #5 CLK = ~CLK;
   // error pulse catcher and hang guard
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (PRIMARY_SYSTEM_ERROR_OUT_OE === 1'b1) pulses <= pulses + 1;
      if (cycles == 5000) begin
         fails++;
         stop_test;
      end
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask
   // bus tasks wait an edge first, so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_WDATA <= v;
      REG_WR <= 1;
      @(posedge CLK) REG_WR <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD <= 1;
      @(posedge CLK) REG_RD <= 0;
      @(posedge CLK) chk("register", e, REG_RDATA);
   endtask
   task automatic load(input logic [1:0] s, k, input logic [31:0] a, input logic [7:0] n, input logic p);
      @(posedge CLK);
      {TXN_SLOT, TXN_KIND, TXN_ADDR, TXN_CMD} <= {s, k, a, CMD_MEM_WRITE_INV};
      {TXN_DWORDS, TXN_PREFETCH, TXN_LOAD} <= {n, p, 1'b1};
      @(posedge CLK) TXN_LOAD <= 0;
   endtask
   // one attempt: address and command, then the end report
   task automatic att(input logic [1:0] s, input logic [2:0] m, input logic [1:0] act, input logic [31:0] a,
      input logic [3:0] c);
      int n;
      @(posedge CLK);
      {ATT_SLOT, ATT_START, mode} <= {s, 1'b1, m};
      @(posedge CLK) {ATT_START, go} <= 2'h1;
      @(posedge CLK) go <= 0;
      chk("attempt address and command", a ^ 32'(c), ATT_ADDR ^ 32'(ATT_CMD));
      for (n = 0; n < 40 && END_VALID !== 1'b1; n++) @(posedge CLK);
      chk("attempt end", 32'({1'b1, s, act}), 32'({END_VALID, END_SLOT, END_ACTION}));
      repeat (4) @(posedge CLK);
   endtask
   task automatic poll(input logic [1:0] s, input logic m, input logic [2:0] r);
      @(posedge CLK);
      {INIT_SLOT, INIT_MORE, INIT_POLL} <= {s, m, 1'b1};
      @(posedge CLK) INIT_POLL <= 0;
      @(posedge CLK) chk("answer", 32'({1'b1, r}), 32'({INIT_RESP_VALID, INIT_RESP}));
   endtask
   // retries to the limit; error pulse only when not disabled
   task automatic lim(input logic [1:0] k, input logic e);
      int p0 = pulses;
      load(2'h1, k, 32'h0000_5000, 8'h01, 1'b0);
      att(2'h1, 3'h0, 2'h1, 32'h0000_5000, CMD_MEM_WRITE_INV);
      att(2'h1, 3'h0, 2'h1, 32'h0000_5000, CMD_MEM_WRITE_INV);
      att(2'h1, 3'h0, 2'h3, 32'h0000_5000, CMD_MEM_WRITE_INV);
      chk("system error pulse", 32'(e), 32'(pulses - p0));
   endtask
   initial begin
      repeat (12) @(posedge CLK);
      SRST <= 0;
      rd(OFS_RETRY_LIMIT, 32'h0100_0000);
      wr(OFS_EVENT_DISABLE, 32'h0000_0010);
      rd(OFS_EVENT_DISABLE, 32'h0000_0010);
      rd(8'h40, 32'h0);
      wr(OFS_CONTROL, 32'h0000_0100);
      load(2'h0, 2'h1, 32'h0000_1000, 8'h02, 1'b0);
      att(2'h0, 3'h0, 2'h1, 32'h0000_1000, CMD_MEM_WRITE_INV);
      att(2'h0, 3'h2, 2'h1, 32'h0000_1000, CMD_MEM_WRITE_INV);
      att(2'h0, 3'h1, 2'h2, 32'h0000_1004, CMD_MEM_WRITE);
      poll(2'h0, 1'b1, 3'h0);
      $display("posted test done");
      load(2'h1, 2'h0, 32'h0000_2000, 8'h01, 1'b0);
      att(2'h1, 3'h0, 2'h1, 32'h0000_2000, CMD_MEM_WRITE_INV);
      poll(2'h1, 1'b1, 3'h1);
      att(2'h1, 3'h1, 2'h2, 32'h0000_2000, CMD_MEM_WRITE_INV);
      poll(2'h1, 1'b1, 3'h3);
      load(2'h2, 2'h2, 32'h0000_3000, 8'h01, 1'b1);
      att(2'h2, 3'h2, 2'h2, 32'h0000_3000, CMD_MEM_WRITE_INV);
      poll(2'h2, 1'b1, 3'h3);
      load(2'h2, 2'h2, 32'h0000_7000, 8'h01, 1'b0);
      att(2'h2, 3'h1, 2'h2, 32'h0000_7000, CMD_MEM_WRITE_INV);
      poll(2'h2, 1'b0, 3'h3);
      load(2'h2, 2'h2, 32'h0000_7000, 8'h01, 1'b1);
      att(2'h2, 3'h1, 2'h2, 32'h0000_7000, CMD_MEM_WRITE_INV);
      poll(2'h2, 1'b0, 3'h2);
      $display("completion test done");
      load(2'h2, 2'h2, 32'h0000_3000, 8'h01, 1'b0);
      att(2'h2, 3'h3, 2'h2, 32'h0000_3000, CMD_MEM_WRITE_INV);
      poll(2'h2, 1'b0, 3'h4);
      rd(OFS_STATUS, 32'h0000_0003);
      wr(OFS_STATUS, 32'h0000_000F);
      load(2'h3, 2'h2, 32'h0000_4000, 8'h01, 1'b0);
      att(2'h3, 3'h4, 2'h2, 32'h0000_4000, CMD_MEM_WRITE_INV);
      poll(2'h3, 1'b0, 3'h5);
      load(2'h0, 2'h1, 32'h0000_6000, 8'h01, 1'b0);
      att(2'h0, 3'h3, 2'h3, 32'h0000_6000, CMD_MEM_WRITE_INV);
      rd(OFS_STATUS, 32'h0000_000D);
      $display("abort test done");
      wr(OFS_RETRY_LIMIT, 32'h0000_0003);
      lim(2'h0, 1'b1);
      wr(OFS_EVENT_DISABLE, 32'h0000_0020);
      lim(2'h2, 1'b0);
      $display("limit test done");
      stop_test;
   end
endmodule
